// ### hw/ivmap.sv
`timescale 1ns/1ps
`include "ivmap_params.svh"

module ivmap (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic vec_req, // Core asks for a vector, one-cycle pulse
  input wire logic [4:0] vec_src, // Source code of the request
  output logic vec_ready, // Sequencer idle, request may be given
  output logic vec_done, // Handler address valid, one-cycle pulse
  output logic vec_err, // Source code has no vector, one-cycle pulse
  output logic [15:0] vec_handler, // Fetched 16-bit handler address
  output logic [15:0] vec_loc, // Vector location being or last fetched
  output logic mem_req, // Byte read request to program memory
  output logic [15:0] mem_addr, // Byte read address
  input wire logic mem_gnt, // Read taken, mem_rdata valid this cycle
  input wire logic [7:0] mem_rdata, // Read data
  input wire logic [15:0] dec_addr, // Address to classify
  output logic dec_direct, // Address in direct-page registers
  output logic [7:0] dec_direct_ofs, // Low byte used by direct addressing
  output logic dec_high, // Address in high-page registers
  output logic dec_nvreg // Address in nonvolatile registers
);

  // ==========================================================
  // Source to vector location lookup
  function automatic logic [16:0] loc_of(input logic [4:0] src);
    logic [16:0] r;
    r = {1'b0, `IVMAP_ADDR_RST};
    case (src)
      ivmap_pkg::SRC_RESET: r = {1'b1, `IVMAP_VEC_RESET};
      ivmap_pkg::SRC_SOFTINT: r = {1'b1, `IVMAP_VEC_SOFTINT};
      ivmap_pkg::SRC_LVD: r = {1'b1, `IVMAP_VEC_LVD};
      ivmap_pkg::SRC_T1CH0: r = {1'b1, `IVMAP_VEC_T1CH0};
      ivmap_pkg::SRC_T1CH1: r = {1'b1, `IVMAP_VEC_T1CH1};
      ivmap_pkg::SRC_T1OVF: r = {1'b1, `IVMAP_VEC_T1OVF};
      ivmap_pkg::SRC_T2CH0: r = {1'b1, `IVMAP_VEC_T2CH0};
      ivmap_pkg::SRC_T2CH1: r = {1'b1, `IVMAP_VEC_T2CH1};
      ivmap_pkg::SRC_T2OVF: r = {1'b1, `IVMAP_VEC_T2OVF};
      ivmap_pkg::SRC_SPI: r = {1'b1, `IVMAP_VEC_SPI};
      ivmap_pkg::SRC_SERERR: r = {1'b1, `IVMAP_VEC_SERERR};
      ivmap_pkg::SRC_SERRX: r = {1'b1, `IVMAP_VEC_SERRX};
      ivmap_pkg::SRC_SERTX: r = {1'b1, `IVMAP_VEC_SERTX};
      ivmap_pkg::SRC_PORTA: r = {1'b1, `IVMAP_VEC_PORTA};
      ivmap_pkg::SRC_PORTB: r = {1'b1, `IVMAP_VEC_PORTB};
      ivmap_pkg::SRC_ADC: r = {1'b1, `IVMAP_VEC_ADC};
      ivmap_pkg::SRC_TWOWIRE: r = {1'b1, `IVMAP_VEC_TWOWIRE};
      ivmap_pkg::SRC_RTC: r = {1'b1, `IVMAP_VEC_RTC};
      ivmap_pkg::SRC_MODTMR: r = {1'b1, `IVMAP_VEC_MODTMR};
      ivmap_pkg::SRC_COMPARATOR: begin
        r = {1'b1, `IVMAP_VEC_COMPARATOR};
      end
      // Unassigned codes get no location and start no fetch
      default: r = {1'b0, `IVMAP_ADDR_RST};
    endcase
    return r;
  endfunction

  ivmap_pkg::ivmap_state_e state_q;
  ivmap_pkg::ivmap_state_e state_d;
  logic [16:0] lookup;
  logic take;
  logic [15:0] loc_q;
  logic [7:0] hi_q;
  logic [15:0] handler_q;
  logic done_q;
  logic err_q;
  logic [15:0] mem_addr_q;
  logic direct_q;
  logic [7:0] direct_ofs_q;
  logic high_q;
  logic nvreg_q;

  assign lookup = loc_of(vec_src);
  assign vec_ready = (state_q == ivmap_pkg::ST_IDLE);
  assign take = vec_req && vec_ready;

  // ==========================================================
  // Fetch sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ivmap_pkg::ST_IDLE: begin
        if (take && lookup[16]) begin
          state_d = ivmap_pkg::ST_HI;
        end
      end
      ivmap_pkg::ST_HI: begin
        if (mem_gnt) begin
          state_d = ivmap_pkg::ST_LO;
        end
      end
      ivmap_pkg::ST_LO: begin
        if (mem_gnt) begin
          state_d = ivmap_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Leaving reset goes straight into the reset vector fetch
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ivmap_pkg::ST_HI;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      loc_q <= `IVMAP_VEC_RESET;
    end else if (take && lookup[16]) begin
      loc_q <= lookup[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_addr_q <= `IVMAP_VEC_RESET;
    end else if (take && lookup[16]) begin
      mem_addr_q <= lookup[15:0];
    end else if (state_q == ivmap_pkg::ST_HI && mem_gnt) begin
      mem_addr_q <= loc_q + `IVMAP_PAIR_STEP;
    end
  end

  // High byte first from the lower address of the pair
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hi_q <= `IVMAP_BYTE_RST;
    end else if (state_q == ivmap_pkg::ST_HI && mem_gnt) begin
      hi_q <= mem_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      handler_q <= `IVMAP_ADDR_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ivmap_pkg::ST_LO) && mem_gnt;
      if (state_q == ivmap_pkg::ST_LO && mem_gnt) begin
        handler_q <= {hi_q, mem_rdata};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      err_q <= 1'b0;
    end else begin
      err_q <= take && !lookup[16];
    end
  end

  // ==========================================================
  // Region decode, registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      direct_q <= 1'b0;
      direct_ofs_q <= `IVMAP_BYTE_RST;
      high_q <= 1'b0;
      nvreg_q <= 1'b0;
    end else begin
      direct_q <= (dec_addr <= `IVMAP_DIR_HI);
      direct_ofs_q <= dec_addr[7:0];
      high_q <= (dec_addr >= `IVMAP_HIGH_LO) &&
                (dec_addr <= `IVMAP_HIGH_HI);
      nvreg_q <= (dec_addr >= `IVMAP_NV_LO) &&
                 (dec_addr <= `IVMAP_NV_HI);
    end
  end

  assign vec_done = done_q;
  assign vec_err = err_q;
  assign vec_handler = handler_q;
  assign vec_loc = loc_q;
  assign mem_req = (state_q != ivmap_pkg::ST_IDLE);
  assign mem_addr = mem_addr_q;
  assign dec_direct = direct_q;
  assign dec_direct_ofs = direct_ofs_q;
  assign dec_high = high_q;
  assign dec_nvreg = nvreg_q;

endmodule

// ### common/ivmap_params.svh
// How it works
// - After any reset the handler address is fetched from 0xFFFE:0xFFFF.
// - The software interrupt instruction vectors through 0xFFFC:0xFFFD.
// - The low supply voltage detector vectors through 0xFFF8:0xFFF9.
// - First timer unit channel 0 uses 0xFFF4, channel 1 uses 0xFFF2.
// - First timer unit overflow uses its own pair at 0xFFE8:0xFFE9.
// - Second timer unit: channel 0 0xFFE6, channel 1 0xFFE4, overflow 0xFFE2
// - Every SPI request shares the single pair at 0xFFE0:0xFFE1.
// - Serial interface: error 0xFFDE, receive 0xFFDC, transmit 0xFFDA.
// - Pin change on port A uses 0xFFD6, port B uses 0xFFD4.
// - Conversion complete vectors through 0xFFD0:0xFFD1.
// - All two-wire bus controller requests share 0xFFCE:0xFFCF.
// - The real-time counter vectors through 0xFFCC:0xFFCD.
// - Modulo timer overflow vectors through 0xFFCA:0xFFCB.
// - Analog comparator events vector through 0xFFC2:0xFFC3.
// - Unassigned pairs such as 0xFFC0 are never fetched by hardware.
// - 0x0000 to 0x007F decodes as direct-page registers.
// - 0x1800 to 0x185F decodes as high-page registers.
// - 0xFFB0 to 0xFFBF decodes as nonvolatile registers.
`ifndef IVMAP_PARAMS_SVH
`define IVMAP_PARAMS_SVH

// ==========================================================
// Vector locations (high byte address of each pair)
`define IVMAP_VEC_RESET 16'hFFFE
`define IVMAP_VEC_SOFTINT 16'hFFFC
`define IVMAP_VEC_LVD 16'hFFF8
`define IVMAP_VEC_T1CH0 16'hFFF4
`define IVMAP_VEC_T1CH1 16'hFFF2
`define IVMAP_VEC_T1OVF 16'hFFE8
`define IVMAP_VEC_T2CH0 16'hFFE6
`define IVMAP_VEC_T2CH1 16'hFFE4
`define IVMAP_VEC_T2OVF 16'hFFE2
`define IVMAP_VEC_SPI 16'hFFE0
`define IVMAP_VEC_SERERR 16'hFFDE
`define IVMAP_VEC_SERRX 16'hFFDC
`define IVMAP_VEC_SERTX 16'hFFDA
`define IVMAP_VEC_PORTA 16'hFFD6
`define IVMAP_VEC_PORTB 16'hFFD4
`define IVMAP_VEC_ADC 16'hFFD0
`define IVMAP_VEC_TWOWIRE 16'hFFCE
`define IVMAP_VEC_RTC 16'hFFCC
`define IVMAP_VEC_MODTMR 16'hFFCA
`define IVMAP_VEC_COMPARATOR 16'hFFC2

// ==========================================================
// Register regions
`define IVMAP_DIR_LO 16'h0000
`define IVMAP_DIR_HI 16'h007F
`define IVMAP_HIGH_LO 16'h1800
`define IVMAP_HIGH_HI 16'h185F
`define IVMAP_NV_LO 16'hFFB0
`define IVMAP_NV_HI 16'hFFBF

// ==========================================================
// Reset values and the step from high to low byte address
`define IVMAP_ADDR_RST 16'h0000
`define IVMAP_BYTE_RST 8'h00
`define IVMAP_PAIR_STEP 16'h0001

`endif

// ### common/ivmap_pkg.sv
package ivmap_pkg;

  // ==========================================================
  // Vector sources presented by the core
  typedef enum logic [4:0] {
    SRC_RESET   = 5'h00,
    SRC_SOFTINT = 5'h01,
    SRC_LVD     = 5'h02,
    SRC_T1CH0   = 5'h03,
    SRC_T1CH1   = 5'h04,
    SRC_T1OVF   = 5'h05,
    SRC_T2CH0   = 5'h06,
    SRC_T2CH1   = 5'h07,
    SRC_T2OVF   = 5'h08,
    SRC_SPI     = 5'h09,
    SRC_SERERR  = 5'h0A,
    SRC_SERRX   = 5'h0B,
    SRC_SERTX   = 5'h0C,
    SRC_PORTA   = 5'h0D,
    SRC_PORTB   = 5'h0E,
    SRC_ADC     = 5'h0F,
    SRC_TWOWIRE = 5'h10,
    SRC_RTC     = 5'h11,
    SRC_MODTMR  = 5'h12,
    SRC_COMPARATOR = 5'h13
  } ivmap_src_e;

  // ==========================================================
  // Fetch sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HI   = 2'b01,
    ST_LO   = 2'b10
  } ivmap_state_e;

endpackage

// ### test/ivmap_monitor.sv
`timescale 1ns/1ps
module ivmap_monitor (
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic vec_req, // Watched
  input wire logic [4:0] vec_src, // Watched
  input wire logic vec_ready, // Watched
  input wire logic vec_done, // Watched
  input wire logic vec_err, // Watched
  input wire logic [15:0] vec_handler, // Watched
  input wire logic [15:0] vec_loc, // Watched
  input wire logic mem_req, // Watched
  input wire logic [15:0] mem_addr, // Watched
  input wire logic mem_gnt, // Watched
  input wire logic [7:0] mem_rdata, // Watched
  input wire logic [15:0] dec_addr, // Watched
  input wire logic dec_direct, // Watched
  input wire logic [7:0] dec_direct_ofs, // Watched
  input wire logic dec_high, // Watched
  input wire logic dec_nvreg // Watched
);
  // ==========================================================
  // Vector fetch
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_vector: assert property (
    $fell(sys_rst) |-> mem_req && mem_addr == 16'hFFFE)
    else $error("reset fetch not at top pair");
  a_swi_vector: assert property (
    vec_req && vec_ready && vec_src == 5'h01 |=>
    mem_req && vec_loc == 16'hFFFC && mem_addr == 16'hFFFC)
    else $error("software interrupt pair wrong");
  a_unassigned_err: assert property (
    vec_req && vec_ready && vec_src > 5'h13 |=> vec_err && !mem_req)
    else $error("unassigned source fetched");
  a_low_follows: assert property (
    mem_req && mem_gnt && mem_addr == vec_loc |=>
    mem_req && mem_addr == vec_loc + 16'h0001)
    else $error("low byte not read next");
  a_done_after_low: assert property (
    mem_req && mem_gnt && mem_addr == vec_loc + 16'h0001 |=>
    vec_done && !mem_req)
    else $error("no done after low byte");
  a_fetch_bounded: assert property (
    vec_req && vec_ready && vec_src <= 5'h13 |-> ##[3:12] vec_done)
    else $error("fetch did not finish");
  a_done_pulse: assert property (
    vec_done |-> vec_ready ##1 !vec_done)
    else $error("done not a single pulse");
  a_handler_low: assert property (
    mem_req && mem_gnt && mem_addr == vec_loc + 16'h0001 |=>
    vec_handler[7:0] == $past(mem_rdata))
    else $error("handler low byte wrong");
  // ==========================================================
  // Region decode
  a_direct_page: assert property (
    1'b1 |=> dec_direct == ($past(dec_addr) <= 16'h007F) &&
    dec_direct_ofs == $past(dec_addr[7:0]))
    else $error("direct page decode wrong");
  a_high_page: assert property (
    1'b1 |=> dec_high == ($past(dec_addr) inside {[16'h1800:16'h185F]}))
    else $error("high page decode wrong");
  a_nv_region: assert property (
    1'b1 |=> dec_nvreg == ($past(dec_addr) inside {[16'hFFB0:16'hFFBF]}))
    else $error("nonvolatile decode wrong");
endmodule

bind ivmap ivmap_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .vec_req(vec_req), .vec_src(vec_src), .vec_ready(vec_ready),
  .vec_done(vec_done), .vec_err(vec_err), .vec_handler(vec_handler),
  .vec_loc(vec_loc), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .dec_addr(dec_addr),
  .dec_direct(dec_direct), .dec_direct_ofs(dec_direct_ofs),
  .dec_high(dec_high), .dec_nvreg(dec_nvreg));

// ### test/ivmap_mem.sv
`timescale 1ns/1ps
module ivmap_mem (
  input wire logic sys_clk, // System clock
  input wire logic mem_req, // Read request
  input wire logic [15:0] mem_addr, // Read address
  input wire logic slow, // Two wait cycles per byte
  output logic mem_gnt, // Read taken
  output logic [7:0] mem_rdata // Read data
);
  logic [1:0] wait_q;
  // Data is only valid with the grant; otherwise inverted
  always_comb begin
    mem_gnt = mem_req && (!slow || wait_q == 2'h2);
    mem_rdata = mem_addr[7:0] ^ (mem_gnt ? 8'h5A : 8'hA5);
  end
  always_ff @(posedge sys_clk) begin
    if (mem_req && !mem_gnt) begin
      wait_q <= wait_q + 2'h1;
    end else begin
      wait_q <= 2'h0;
    end
  end
endmodule

// ### test/ivmap_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module ivmap_test;
  logic sys_clk, sys_rst, vec_req, vec_ready, vec_done, vec_err;
  logic mem_req, mem_gnt, slow, dec_direct, dec_high, dec_nvreg;
  logic [4:0] vec_src;
  logic [15:0] vec_handler, vec_loc, mem_addr, dec_addr;
  logic [7:0] mem_rdata, dec_direct_ofs;
  int failures, tests_run;
  localparam logic [15:0] LOCS [20] = '{16'hFFFE, 16'hFFFC, 16'hFFF8,
    16'hFFF4, 16'hFFF2, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0,
    16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD6, 16'hFFD4, 16'hFFD0, 16'hFFCE,
    16'hFFCC, 16'hFFCA, 16'hFFC2};
  localparam logic [15:0] DECS [10] = '{16'h007F, 16'h0080, 16'h17FF,
    16'h1800, 16'h185F, 16'h1860, 16'hFFAF, 16'hFFB0, 16'hFFBF, 16'hFFC0};

  ivmap dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .vec_req(vec_req),
    .vec_src(vec_src), .vec_ready(vec_ready), .vec_done(vec_done),
    .vec_err(vec_err), .vec_handler(vec_handler), .vec_loc(vec_loc),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata), .dec_addr(dec_addr), .dec_direct(dec_direct),
    .dec_direct_ofs(dec_direct_ofs), .dec_high(dec_high),
    .dec_nvreg(dec_nvreg));
  ivmap_mem u_mem (.sys_clk(sys_clk), .mem_req(mem_req),
    .mem_addr(mem_addr), .slow(slow), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata));

  // ==========================================================
  // Tasks
  task automatic await_done(input logic [15:0] loc);
    int n;
    n = 0;
    while (vec_done !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(vec_done, 1'b1)
    `CHK(vec_loc, loc)
    `CHK(vec_handler, {loc[7:0] ^ 8'h5A, loc[7:0] + 8'h01 ^ 8'h5A})
  endtask
  task automatic run_vectors();
    for (int i = 0; i < 20; i++) begin
      slow = i[0];
      vec_req = 1'b1;
      vec_src = i[4:0];
      @(negedge sys_clk);
      vec_req = 1'b0;
      await_done(LOCS[i]);
    end
  endtask
  task automatic run_unassigned();
    for (int i = 20; i < 32; i++) begin
      vec_req = 1'b1;
      vec_src = i[4:0];
      @(negedge sys_clk);
      `CHK(vec_err, 1'b1)
      `CHK(mem_req, 1'b0)
    end
    vec_req = 1'b0;
  endtask
  task automatic run_decode();
    logic [15:0] a;
    for (int i = 0; i < 10; i++) begin
      a = DECS[i];
      dec_addr = a;
      @(negedge sys_clk);
      `CHK(dec_direct, a <= 16'h007F)
      `CHK(dec_direct_ofs, a[7:0])
      `CHK(dec_high, a >= 16'h1800 && a <= 16'h185F)
      `CHK(dec_nvreg, a >= 16'hFFB0 && a <= 16'hFFBF)
    end
  endtask
  task automatic run_reset_mid();
    vec_req = 1'b1;
    vec_src = 5'h01;
    @(negedge sys_clk);
    vec_req = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    await_done(16'hFFFE);
  endtask
  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    vec_req = 1'b0;
    vec_src = 5'h00;
    dec_addr = 16'h0000;
    slow = 1'b1;
    failures = 0;
    tests_run = 0;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    await_done(16'hFFFE);
    run_vectors();
    run_unassigned();
    run_decode();
    run_reset_mid();
    finish_test();
  end
endmodule
